// [core/cgsr_consts.svh]
/*
 * Offsets, field positions, write masks and reset values of the clock
 * gating and software reset block.
 * Assumes a 12-bit byte address from the APB slave port.
 */
`ifndef CGSR_CONSTS_SVH
`define CGSR_CONSTS_SVH

// Register byte offsets
`define CGSR_OFF_SRST_A 12'h040
`define CGSR_OFF_SRST_B 12'h044
`define CGSR_OFF_STATUS 12'h050
`define CGSR_OFF_MASK 12'h054
`define CGSR_OFF_RUN_CFG 12'h060
`define CGSR_OFF_RUN_GATE 12'h108
`define CGSR_OFF_SLEEP_GATE 12'h118
`define CGSR_OFF_DEEP_GATE 12'h128

// Gating register fields
`define CGSR_BIT_ETHER_XCVR 30
`define CGSR_BIT_ETHER_MAC 28
`define CGSR_BIT_PORT_G 6
`define CGSR_BIT_PORT_A 0
`define CGSR_GATE_WMASK 32'h5000007f

// Software reset register fields
`define CGSR_BIT_CAN 24
`define CGSR_BIT_HIB 6
`define CGSR_BIT_WDOG 3
`define CGSR_SRST_A_WMASK 32'h01000048
`define CGSR_BIT_CNT3 19
`define CGSR_BIT_CNT0 16
`define CGSR_BIT_TWI 12
`define CGSR_BIT_SSP 4
`define CGSR_BIT_SER1 1
`define CGSR_BIT_SER0 0
`define CGSR_SRST_B_WMASK 32'h000f1013

// Run-mode configuration and event fields
`define CGSR_BIT_AUTO_GATE 27
`define CGSR_BIT_EV_FAULT 0
`define CGSR_BIT_EV_RESET 1
`define CGSR_EV_WMASK 32'h00000003

// Reset values
`define CGSR_RST_GATE 32'h00000000
`define CGSR_RST_SRST 32'h00000000
`define CGSR_RST_ZERO 32'h00000000

`endif

// [core/cgsr_gate_sel.sv]
/*
 * Picks the gating set for the current power mode and registers the
 * resulting unit clock enables.
 * Assumes mode and the three gating sets are on the pclk domain.
 */
module cgsr_gate_sel (
  input wire logic pclk,
  input wire logic presetn,
  input wire cgsr_pkg::cgsr_mode_t mode,
  input wire logic auto_gate,
  input wire cgsr_pkg::cgsr_units_t run_set,
  input wire cgsr_pkg::cgsr_units_t sleep_set,
  input wire cgsr_pkg::cgsr_units_t deep_set,
  output cgsr_pkg::cgsr_units_t gate_en_q
);

  cgsr_pkg::cgsr_units_t sel_d;

  // Low-power sets only count with automatic gating on
  always_comb begin
    sel_d = run_set;
    if (auto_gate) begin
      unique case (mode)
        cgsr_pkg::CGSR_RUN: sel_d = run_set;
        cgsr_pkg::CGSR_SLEEP: sel_d = sleep_set;
        cgsr_pkg::CGSR_DEEP: sel_d = deep_set;
        default: sel_d = run_set;
      endcase
    end
  end

  // Enable flop feeds the unit clock gate cells without glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gate_en_q <= '0;
    end else begin
      gate_en_q <= sel_d;
    end
  end

endmodule

// [core/cgsr_pkg.sv]
/*
 * Types shared by the clock gating and soft reset block.
 * Assumes the constants header supplies all numeric values.
 */
package cgsr_pkg;

  // Power mode reported by the processor core
  typedef enum logic [1:0] {
    CGSR_RUN = 2'b00,
    CGSR_SLEEP = 2'b01,
    CGSR_DEEP = 2'b10
  } cgsr_mode_t;

  // One enable or strobe per gated unit
  typedef struct packed {
    logic ether_xcvr;
    logic ether_mac;
    logic [6:0] port;
  } cgsr_units_t;

  // One reset request per resettable unit
  typedef struct packed {
    logic ctrl_area_net;
    logic hibernation;
    logic watchdog;
    logic [3:0] gp_counter;
    logic two_wire;
    logic sync_serial;
    logic serial_port1;
    logic serial_port0;
  } cgsr_resets_t;

endpackage

// [core/cgsr_top.sv]
/*
 * Clock gating and software reset control with an APB register port.
 * Holds three gating sets, two software reset registers, an event
 * status and mask pair, and the registered unit enables and resets.
 * Register map, one 32-bit word per byte offset:
 *   0x040 soft_reset_ctl_a, writes masked by capability_mask_a
 *   0x044 soft_reset_ctl_b, writes masked by capability_mask_b
 *   0x050 event status: bit 0 gated access, bit 1 reset set; W1C
 *   0x054 event mask, same layout as the status
 *   0x060 run_mode_clock_config, auto_gating_select at bit 27
 *   0x108 run_clock_gate, the set used while running
 *   0x118 sleep_clock_gate, the set used in sleep
 *   0x128 deep_sleep_clock_gate, the set used in deep sleep
 * Gating sets hold the transceiver at 30, the MAC at 28 and the
 * ports G to A at 6:0; every other bit reads zero.
 * Each transfer answers in its first access cycle; unmapped offsets
 * and writes with partial strobes get an error and change nothing.
 * Assumes the interconnect signals each unit access on unit_access in
 * the same pclk domain, and that capability masks are static straps
 * already on pclk. Each unit's clock gate cell is expected to latch
 * unit_clk_en while pclk is low, so that a change never shortens a
 * unit clock pulse.
 */
// Design decision made here: the APB slave port.
`include "cgsr_consts.svh"

module cgsr_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire cgsr_pkg::cgsr_mode_t mode,
  input wire logic [31:0] capability_mask_a,
  input wire logic [31:0] capability_mask_b,
  input wire cgsr_pkg::cgsr_units_t unit_access,
  output cgsr_pkg::cgsr_units_t unit_clk_en,
  output cgsr_pkg::cgsr_units_t unit_fault,
  output cgsr_pkg::cgsr_resets_t unit_reset,
  output logic irq
);

  // One enable, access and fault bit per gated unit
  localparam int NUM_UNITS = $bits(cgsr_pkg::cgsr_units_t);

  // Register state
  // Each gating set and reset register is one full 32-bit word
  logic [31:0] run_clock_gate_q;
  logic [31:0] run_clock_gate_d;
  logic [31:0] sleep_clock_gate_q;
  logic [31:0] sleep_clock_gate_d;
  logic [31:0] deep_sleep_clock_gate_q;
  logic [31:0] deep_sleep_clock_gate_d;
  logic [31:0] soft_reset_ctl_a_q;
  logic [31:0] soft_reset_ctl_a_d;
  logic [31:0] soft_reset_ctl_b_q;
  logic [31:0] soft_reset_ctl_b_d;
  logic auto_gating_select_q;
  logic auto_gating_select_d;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [31:0] mask_q;
  logic [31:0] mask_d;

  // Bus output flops
  // Answer flops, so the bus outputs carry no decode glitches
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic irq_q;

  // Unit side flops
  // Registered unit signals, one per enable, fault and reset
  cgsr_pkg::cgsr_units_t gate_en_q;
  cgsr_pkg::cgsr_units_t fault_q;
  cgsr_pkg::cgsr_resets_t reset_q;

  // Address decode
  // Full 12-bit compare: aliases of a register are unmapped
  wire sel_srst_a = (paddr == `CGSR_OFF_SRST_A);
  wire sel_srst_b = (paddr == `CGSR_OFF_SRST_B);
  wire sel_status = (paddr == `CGSR_OFF_STATUS);
  wire sel_mask = (paddr == `CGSR_OFF_MASK);
  wire sel_run_cfg = (paddr == `CGSR_OFF_RUN_CFG);
  wire sel_run_gate = (paddr == `CGSR_OFF_RUN_GATE);
  wire sel_sleep_gate = (paddr == `CGSR_OFF_SLEEP_GATE);
  wire sel_deep_gate = (paddr == `CGSR_OFF_DEEP_GATE);
  wire sel_any = sel_srst_a | sel_srst_b | sel_status | sel_mask |
    sel_run_cfg | sel_run_gate | sel_sleep_gate | sel_deep_gate;

  // Transfer phases: answer in the first cycle of the access phase
  // The answer is built from the setup cycle, so the slave never
  // stretches a transfer and the master needs no wait counter
  wire setup_ph = psel & ~penable;
  wire done_ph = psel & penable & pready_q;
  // A refused transfer never reaches a register
  wire wr_en = done_ph & pwrite & ~pslverr_q;
  // Writes must carry all four byte lanes
  wire full_word = (pstrb == 4'hf);

  // Write strobes per register; partial writes are refused
  // A byte lane merge would need read-modify logic per register;
  // refusing it keeps every register a plain word store
  wire wr_srst_a = wr_en & full_word & sel_srst_a;
  wire wr_srst_b = wr_en & full_word & sel_srst_b;
  wire wr_status = wr_en & full_word & sel_status;
  wire wr_mask = wr_en & full_word & sel_mask;
  wire wr_run_cfg = wr_en & full_word & sel_run_cfg;
  wire wr_run_gate = wr_en & full_word & sel_run_gate;
  wire wr_sleep_gate = wr_en & full_word & sel_sleep_gate;
  wire wr_deep_gate = wr_en & full_word & sel_deep_gate;

  // Reset writes keep bits of absent units unchanged
  // The capability straps clear lanes of units not fitted, so a
  // write of all ones can never hold a missing unit in reset
  wire [31:0] srst_a_wm = `CGSR_SRST_A_WMASK & capability_mask_a;
  wire [31:0] srst_b_wm = `CGSR_SRST_B_WMASK & capability_mask_b;

  // Unmapped address or a partial write gives an error answer
  // Decoded from the setup cycle and held in the answer flop
  wire err_d = ~sel_any | (pwrite & ~full_word);

  // Read mux; unused positions are zero in every register
  // Selects are one-hot, so an AND-OR tree needs no priority chain
  wire [31:0] rd_cfg = {4'h0, auto_gating_select_q, 27'h0000000};
  wire [31:0] rd_data =
    ({32{sel_srst_a}} & soft_reset_ctl_a_q) |
    ({32{sel_srst_b}} & soft_reset_ctl_b_q) |
    ({32{sel_status}} & status_q) |
    ({32{sel_mask}} & mask_q) |
    ({32{sel_run_cfg}} & rd_cfg) |
    ({32{sel_run_gate}} & run_clock_gate_q) |
    ({32{sel_sleep_gate}} & sleep_clock_gate_q) |
    ({32{sel_deep_gate}} & deep_sleep_clock_gate_q);

  // Gating sets keep only implemented enables
  // Masking at write time means reads show only the units fitted
  assign run_clock_gate_d = wr_run_gate ?
    (pwdata & `CGSR_GATE_WMASK) : run_clock_gate_q;
  assign sleep_clock_gate_d = wr_sleep_gate ?
    (pwdata & `CGSR_GATE_WMASK) : sleep_clock_gate_q;
  assign deep_sleep_clock_gate_d = wr_deep_gate ?
    (pwdata & `CGSR_GATE_WMASK) : deep_sleep_clock_gate_q;
  // Only the automatic gating bit of the configuration is kept
  assign auto_gating_select_d = wr_run_cfg ?
    pwdata[`CGSR_BIT_AUTO_GATE] : auto_gating_select_q;

  // Software reset registers with capability masking
  // Masked lanes keep their old value rather than being cleared
  assign soft_reset_ctl_a_d = wr_srst_a ?
    ((soft_reset_ctl_a_q & ~srst_a_wm) | (pwdata & srst_a_wm)) :
    soft_reset_ctl_a_q;
  assign soft_reset_ctl_b_d = wr_srst_b ?
    ((soft_reset_ctl_b_q & ~srst_b_wm) | (pwdata & srst_b_wm)) :
    soft_reset_ctl_b_q;

  // Register field views of the gating sets
  // Maps the sparse register bits onto the packed unit struct
  function automatic cgsr_pkg::cgsr_units_t to_units(
    input logic [31:0] r
  );
    cgsr_pkg::cgsr_units_t u;
    u.ether_xcvr = r[`CGSR_BIT_ETHER_XCVR];
    u.ether_mac = r[`CGSR_BIT_ETHER_MAC];
    u.port = r[`CGSR_BIT_PORT_G:`CGSR_BIT_PORT_A];
    return u;
  endfunction

  // Unit views of the three gating sets
  wire cgsr_pkg::cgsr_units_t run_set = to_units(run_clock_gate_q);
  wire cgsr_pkg::cgsr_units_t sleep_set = to_units(sleep_clock_gate_q);
  wire cgsr_pkg::cgsr_units_t deep_set =
    to_units(deep_sleep_clock_gate_q);

  // Reset requests gathered from both registers
  // Wired straight from the register flops; the output flop below
  // adds one edge so every unit sees a clean level
  cgsr_pkg::cgsr_resets_t reset_d;
  assign reset_d.ctrl_area_net = soft_reset_ctl_a_q[`CGSR_BIT_CAN];
  assign reset_d.hibernation = soft_reset_ctl_a_q[`CGSR_BIT_HIB];
  assign reset_d.watchdog = soft_reset_ctl_a_q[`CGSR_BIT_WDOG];
  assign reset_d.gp_counter =
    soft_reset_ctl_b_q[`CGSR_BIT_CNT3:`CGSR_BIT_CNT0];
  assign reset_d.two_wire = soft_reset_ctl_b_q[`CGSR_BIT_TWI];
  assign reset_d.sync_serial = soft_reset_ctl_b_q[`CGSR_BIT_SSP];
  assign reset_d.serial_port1 = soft_reset_ctl_b_q[`CGSR_BIT_SER1];
  assign reset_d.serial_port0 = soft_reset_ctl_b_q[`CGSR_BIT_SER0];

  // Mode and enable selection, registered in the leaf
  // The leaf owns the enable flops, so a mode change reaches the units
  // on the following edge and a gating write on the edge after that
  cgsr_gate_sel u_gate_sel (
    .pclk(pclk),
    .presetn(presetn),
    .mode(mode),
    .auto_gate(auto_gating_select_q),
    .run_set(run_set),
    .sleep_set(sleep_set),
    .deep_set(deep_set),
    .gate_en_q(gate_en_q)
  );

  // Per-unit fault detection on accesses to unclocked units
  // The check uses the registered enable, which is the clock state
  // the unit actually has in this cycle
  // Fault flags in unit order, one per generate pass
  logic [NUM_UNITS-1:0] fault_d;
  genvar gi;
  generate
    for (gi = 0; gi < NUM_UNITS; gi++) begin : g_fault
      assign fault_d[gi] = unit_access[gi] & ~gate_en_q[gi];
    end
  endgenerate

  // Events: a blocked access, or a reset bit newly set
  // A reset bit counts once, on the edge its request rises
  wire ev_fault = |fault_d;
  wire ev_reset = |(reset_d & ~reset_q);
  // Event word in the status layout
  wire [31:0] ev_set = {30'h00000000, ev_reset, ev_fault};
  // Only defined event bits can be cleared
  wire [31:0] clr_bits = wr_status ?
    (pwdata & `CGSR_EV_WMASK) : 32'h00000000;

  // Sticky status: an event in the clear cycle wins
  // Software clearing a stale bit must not lose a fresh event
  assign status_d = (status_q & ~clr_bits) | ev_set;
  // Mask keeps only defined event bits
  assign mask_d = wr_mask ? (pwdata & `CGSR_EV_WMASK) : mask_q;

  // Gating and configuration registers
  // All sets start cleared, so every unit starts unclocked
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      run_clock_gate_q <= `CGSR_RST_GATE;
      sleep_clock_gate_q <= `CGSR_RST_GATE;
      deep_sleep_clock_gate_q <= `CGSR_RST_GATE;
      auto_gating_select_q <= 1'b0;
    end else begin
      run_clock_gate_q <= run_clock_gate_d;
      sleep_clock_gate_q <= sleep_clock_gate_d;
      deep_sleep_clock_gate_q <= deep_sleep_clock_gate_d;
      auto_gating_select_q <= auto_gating_select_d;
    end
  end

  // Software reset registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_reset_ctl_a_q <= `CGSR_RST_SRST;
      soft_reset_ctl_b_q <= `CGSR_RST_SRST;
    end else begin
      soft_reset_ctl_a_q <= soft_reset_ctl_a_d;
      soft_reset_ctl_b_q <= soft_reset_ctl_b_d;
    end
  end

  // Event status and mask
  // Status and mask reset together, so no stale interrupt survives
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_q <= `CGSR_RST_ZERO;
      mask_q <= `CGSR_RST_ZERO;
    end else begin
      status_q <= status_d;
      mask_q <= mask_d;
    end
  end

  // Unit reset and fault outputs, one edge after the register
  // A fault pulse lasts one cycle for each blocked access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_q <= '0;
      fault_q <= '0;
    end else begin
      reset_q <= reset_d;
      fault_q <= fault_d;
    end
  end

  // Interrupt level from unmasked sticky status
  // Built from next values so the level follows a write at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_d & mask_d);
    end
  end

  // APB answer: ready, error and read data captured in setup
  // Read data holds after the answer until the next setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph & err_d;
      if (setup_ph) begin
        prdata_q <= (pwrite | err_d) ? 32'h00000000 : rd_data;
      end
    end
  end

  // Outputs straight from flops
  // No logic between these flops and the pins
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign unit_clk_en = gate_en_q;
  assign unit_fault = fault_q;
  assign unit_reset = reset_q;
  assign irq = irq_q;

endmodule

// [testbench/cgsr_apb_host.sv]
/* APB master standing in for the processor core.
   Assumes one pclk domain; the bench calls xfer hierarchically. */
module cgsr_apb_host (
  input wire logic pclk,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  output logic psel = 1'b0,
  output logic penable = 1'b0,
  output logic pwrite = 1'b0,
  output logic [11:0] paddr = 12'h000,
  output logic [31:0] pwdata = 32'h0,
  output logic [3:0] pstrb = 4'hf
);
  timeunit 1ns;
  timeprecision 1ns;
  // One whole transfer, held until ready is seen at a rising edge
  task automatic xfer(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s, output logic [31:0] r,
      output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    pwdata <= ~d;
  endtask
endmodule

// [testbench/cgsr_top_sva.sv]
/* Checker for the clock gating and soft reset block.
   Assumes it is bound to cgsr_top and sees only its ports. */
module cgsr_top_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire cgsr_pkg::cgsr_mode_t mode,
  input wire cgsr_pkg::cgsr_units_t unit_access,
  input wire cgsr_pkg::cgsr_units_t unit_clk_en,
  input wire cgsr_pkg::cgsr_units_t unit_fault,
  input wire cgsr_pkg::cgsr_resets_t unit_reset
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Offsets that answer without an error
  wire logic mapped = paddr inside {12'h040, 12'h044, 12'h050, 12'h054,
    12'h060, 12'h108, 12'h118, 12'h128};
  ready_pulse_a: assert property (psel && !penable |=> pready && penable)
    else $error("no ready in first access cycle");
  ready_single_a: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  unmapped_err_a: assert property (
    psel && !penable && !mapped |=> pslverr)
    else $error("unmapped offset not refused");
  mapped_ok_a: assert property (psel && !penable && mapped && pstrb == 4'hf
    |=> !pslverr) else $error("mapped offset refused");
  err_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error without ready or with data");
  gated_fault_a: assert property (1 |=> unit_fault ==
    ($past(unit_access) & ~$past(unit_clk_en))) else $error("fault wrong");
  gate_change_a: assert property ($changed(unit_clk_en) |->
    $past(pwrite && penable && pready, 2) || $past(mode) != $past(mode, 2))
    else $error("enable changed without cause");
  reset_change_a: assert property ($changed(unit_reset) |->
    $past(pwrite && penable && pready, 2))
    else $error("reset changed without write");
endmodule

bind cgsr_top cgsr_top_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .pstrb, .prdata, .pready, .pslverr, .mode, .unit_access,
  .unit_clk_en, .unit_fault, .unit_reset);

// [testbench/test_clock_gate_and_soft_reset.sv]
/* Self-checking bench for the clock gating and soft reset block.
   Assumes the APB host model and the bound checker are compiled. */
module test_clock_gate_and_soft_reset;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, ev;
  logic [11:0] paddr;
  logic [3:0] pstrb;
  logic [31:0] pwdata, prdata, rv;
  logic [31:0] cap_a = 32'hffffffff;
  logic [31:0] cap_b = 32'h00000003;
  cgsr_pkg::cgsr_mode_t mode = cgsr_pkg::CGSR_RUN;
  cgsr_pkg::cgsr_units_t access = '0;
  cgsr_pkg::cgsr_units_t clk_en, fault;
  cgsr_pkg::cgsr_resets_t rst;
  int bad_count = 0;
  int n_compared = 0;

  cgsr_apb_host host (.pclk, .prdata, .pready, .pslverr, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pstrb);
  cgsr_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .prdata, .pready, .pslverr, .mode, .capability_mask_a(cap_a),
    .capability_mask_b(cap_b), .unit_access(access), .unit_clk_en(clk_en),
    .unit_fault(fault), .unit_reset(rst), .irq);

  // 100 ns clock
  initial begin
    forever #50 pclk = ~pclk;
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    host.xfer(1'b0, a, 32'h0, 4'hf, rv, ev);
    chk(rv, exp);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host.xfer(1'b1, a, d, 4'hf, rv, ev);
    chk({31'h0, ev}, 32'h0);
  endtask
  // Let the registered outputs follow the last edge
  task automatic settle;
    @(posedge pclk);
    #1;
  endtask
  task automatic set_mode(input cgsr_pkg::cgsr_mode_t m);
    @(posedge pclk);
    mode <= m;
    settle();
  endtask

  task automatic t_reset;
    #1;
    chk({23'h0, clk_en}, 32'h0);
    chk({21'h0, rst}, 32'h0);
    rdchk(12'h108, 32'h0);
    rdchk(12'h118, 32'h0);
    rdchk(12'h128, 32'h0);
    rdchk(12'h040, 32'h0);
    rdchk(12'h044, 32'h0);
    rdchk(12'h0fc, 32'h0);
    chk({31'h0, ev}, 32'h1);
    $display("reset values done");
  endtask
  task automatic t_gate;
    wr(12'h128, 32'hffffffff);
    rdchk(12'h128, 32'h5000007f);
    host.xfer(1'b1, 12'h128, 32'h0, 4'h3, rv, ev);
    chk({31'h0, ev}, 32'h1);
    rdchk(12'h128, 32'h5000007f);
    set_mode(cgsr_pkg::CGSR_DEEP);
    chk({23'h0, clk_en}, 32'h0);
    wr(12'h060, 32'h08000000);
    settle();
    chk({23'h0, clk_en}, 32'h1ff);
    wr(12'h108, 32'h10000005);
    set_mode(cgsr_pkg::CGSR_SLEEP);
    chk({23'h0, clk_en}, 32'h0);
    set_mode(cgsr_pkg::cgsr_mode_t'(2'b11));
    chk({23'h0, clk_en}, 32'h085);
    set_mode(cgsr_pkg::CGSR_RUN);
    chk({23'h0, clk_en}, 32'h085);
    $display("gating sets done");
  endtask
  task automatic t_fault;
    wr(12'h050, 32'h3);
    @(posedge pclk);
    access <= '1;
    @(posedge pclk);
    access <= '0;
    #1;
    chk({23'h0, fault}, 32'h17a);
    settle();
    chk({23'h0, fault}, 32'h0);
    rdchk(12'h050, 32'h1);
    chk({31'h0, irq}, 32'h0);
    wr(12'h054, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h1);
    wr(12'h050, 32'h1);
    settle();
    chk({31'h0, irq}, 32'h0);
    $display("gated access done");
  endtask
  task automatic t_srst;
    wr(12'h040, 32'hffffffff);
    settle();
    chk({21'h0, rst}, 32'h700);
    rdchk(12'h040, 32'h01000048);
    wr(12'h044, 32'hffffffff);
    rdchk(12'h044, 32'h3);
    cap_b <= 32'hffffffff;
    wr(12'h044, 32'hffffffff);
    rdchk(12'h044, 32'h000f1013);
    chk({21'h0, rst}, 32'h7ff);
    rdchk(12'h050, 32'h2);
    host.xfer(1'b0, 12'h040, 32'h0, 4'hf, rv, ev);
    wr(12'h040, rv & ~32'h8);
    cap_a <= 32'h0;
    wr(12'h040, 32'h0);
    rdchk(12'h040, 32'h01000040);
    chk({21'h0, rst}, 32'h6ff);
    $display("soft resets done");
  endtask

  task automatic t_rerun;
    @(posedge pclk);
    presetn <= 1'b0;
    #1;
    chk({23'h0, clk_en}, 32'h0);
    chk({21'h0, rst}, 32'h0);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h040, 32'h0);
    rdchk(12'h044, 32'h0);
    rdchk(12'h108, 32'h0);
    rdchk(12'h050, 32'h0);
    rdchk(12'h060, 32'h0);
    chk({31'h0, irq}, 32'h0);
    $display("mid-run reset done");
  endtask

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Main sequence after 8 cycles of reset
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_gate();
    t_fault();
    t_srst();
    t_rerun();
    results();
  end
  // Watchdog at 2000 cycles, well beyond the roughly 125 cycles needed
  initial begin
    #200000;
    bad_count++;
    results();
  end
endmodule
